// [src/vpat_arb_table.sv]
// Port arbitration table and phase walker for VC resource 0
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps

module vpat_arb_table
(
    // Clock and reset
    input  wire logic                        mclk_in,
    input  wire logic                        rst_in,
    // Register port
    input  wire logic [vpat_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [vpat_pkg::DATA_W-1:0] wdata_in,
    input  wire logic                        wr_in,
    input  wire logic                        rd_in,
    output logic      [vpat_pkg::DATA_W-1:0] rdata_out,
    // Arbitration result
    output logic      [vpat_pkg::SLOT_W-1:0] grant_port_out,
    output logic                             grant_valid_out,
    output logic      [vpat_pkg::PHASE_W-1:0] phase_out,
    output logic                             table_coherence_flag_out
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [vpat_pkg::SLOT_W-1:0] slot_of
    (
        input logic [vpat_pkg::DATA_W*3-1:0]  tbl,
        input logic [vpat_pkg::PHASE_W-1:0]   ph
    );
        slot_of = tbl[ph*vpat_pkg::SLOT_W +: vpat_pkg::SLOT_W];
    endfunction : slot_of

    function automatic logic [vpat_pkg::PHASE_W-1:0] next_phase
    (
        input logic [vpat_pkg::PHASE_W-1:0] ph
    );
        if (ph == vpat_pkg::PHASE_LAST)
            next_phase = vpat_pkg::PHASE_ZERO;
        else
            next_phase = ph + 5'h01;
    endfunction : next_phase

    ////////////////////////////////////////////////////////////////////////
    vpat_pkg::vpat_req_s req;
    assign req = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};

    // Shadow table is what software writes; active table is what arbitrates
    logic [vpat_pkg::DATA_W*3-1:0]   shadow_r;
    logic [vpat_pkg::DATA_W*3-1:0]   shadow_nxt;
    logic [vpat_pkg::DATA_W*3-1:0]   active_r;
    logic [vpat_pkg::DATA_W*3-1:0]   active_nxt;
    logic [vpat_pkg::PORTS-1:0]      valid_r;
    logic [vpat_pkg::PORTS-1:0]      valid_nxt;
    logic [vpat_pkg::PERIOD_W-1:0]   period_r;
    logic [vpat_pkg::PERIOD_W-1:0]   period_nxt;
    logic                            en_r;
    logic                            en_nxt;
    logic                            coh_r;
    logic                            coh_nxt;
    logic [vpat_pkg::DATA_W-1:0]     rdata_r;
    logic [vpat_pkg::DATA_W-1:0]     rdata_nxt;
    vpat_pkg::vpat_state_e           state_r;
    vpat_pkg::vpat_state_e           state_nxt;
    logic [vpat_pkg::PHASE_W-1:0]    phase_r;
    logic [vpat_pkg::PHASE_W-1:0]    phase_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Register file
    logic load_req;
    logic load_done;

    always_comb
    begin
        shadow_nxt = shadow_r;
        valid_nxt  = valid_r;
        period_nxt = period_r;
        en_nxt     = en_r;
        coh_nxt    = coh_r;
        rdata_nxt  = vpat_pkg::RD_ZERO;
        load_req   = 1'b0;
        if (load_done)
            coh_nxt = 1'b0;
        if (req.wr)
        begin
            unique case (req.addr)
                vpat_pkg::OFF_TBL0:
                begin
                    shadow_nxt[31:0] = req.wdata;
                    coh_nxt          = 1'b1;
                end
                vpat_pkg::OFF_TBL1:
                begin
                    shadow_nxt[63:32] = req.wdata;
                    coh_nxt           = 1'b1;
                end
                vpat_pkg::OFF_TBL2:
                begin
                    shadow_nxt[95:64] = req.wdata;
                    coh_nxt           = 1'b1;
                end
                vpat_pkg::OFF_CTRL:
                begin
                    load_req = req.wdata[vpat_pkg::CTRL_LOAD_BIT];
                    en_nxt   = req.wdata[vpat_pkg::CTRL_EN_BIT];
                end
                vpat_pkg::OFF_VALID:
                    valid_nxt = req.wdata[vpat_pkg::PORTS-1:0];
                vpat_pkg::OFF_PERIOD:
                    period_nxt = req.wdata[vpat_pkg::PERIOD_W-1:0];
                default:
                    ;
            endcase
        end
        if (req.rd)
        begin
            unique case (req.addr)
                vpat_pkg::OFF_TBL0:   rdata_nxt = shadow_r[31:0];
                vpat_pkg::OFF_TBL1:   rdata_nxt = shadow_r[63:32];
                vpat_pkg::OFF_TBL2:   rdata_nxt = shadow_r[95:64];
                vpat_pkg::OFF_CTRL:   rdata_nxt[vpat_pkg::CTRL_EN_BIT] = en_r;
                vpat_pkg::OFF_VALID:  rdata_nxt[vpat_pkg::PORTS-1:0] = valid_r;
                vpat_pkg::OFF_PERIOD: rdata_nxt[vpat_pkg::PERIOD_W-1:0] = period_r;
                vpat_pkg::OFF_STAT:
                begin
                    rdata_nxt[vpat_pkg::STAT_COH_BIT]  = coh_r;
                    rdata_nxt[vpat_pkg::STAT_LOAD_BIT] = (state_r == vpat_pkg::ARB_LOAD);
                    rdata_nxt[vpat_pkg::STAT_PH_LSB +: vpat_pkg::PHASE_W] = phase_r;
                end
                default:
                    rdata_nxt = vpat_pkg::RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            shadow_r <= {vpat_pkg::RST_TBL2, vpat_pkg::RST_TBL1, vpat_pkg::RST_TBL0};
            valid_r  <= vpat_pkg::RST_VALID;
            period_r <= vpat_pkg::RST_PERIOD;
            en_r     <= 1'b0;
            coh_r    <= 1'b0;
            rdata_r  <= vpat_pkg::RD_ZERO;
        end
        else
        begin
            shadow_r <= shadow_nxt;
            valid_r  <= valid_nxt;
            period_r <= period_nxt;
            en_r     <= en_nxt;
            coh_r    <= coh_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase walker
    logic [vpat_pkg::PERIOD_W-1:0]  cnt_r;
    logic [vpat_pkg::PERIOD_W-1:0]  cnt_nxt;
    logic [vpat_pkg::SLOT_W-1:0]    gport_r;
    logic [vpat_pkg::SLOT_W-1:0]    gport_nxt;
    logic                           gval_r;
    logic                           gval_nxt;
    logic [vpat_pkg::SLOT_W-1:0]    cur_slot;

    assign cur_slot  = slot_of(active_r, phase_r);
    assign load_done = (state_r == vpat_pkg::ARB_LOAD);

    always_comb
    begin
        state_nxt  = state_r;
        phase_nxt  = phase_r;
        cnt_nxt    = cnt_r;
        active_nxt = active_r;
        gport_nxt  = gport_r;
        gval_nxt   = 1'b0;
        unique case (state_r)
            vpat_pkg::ARB_IDLE:
            begin
                phase_nxt = vpat_pkg::PHASE_ZERO;
                cnt_nxt   = '0;
                if (load_req)
                    state_nxt = vpat_pkg::ARB_LOAD;
                else if (en_r)
                    state_nxt = vpat_pkg::ARB_RUN;
            end
            vpat_pkg::ARB_RUN:
            begin
                if (load_req)
                    state_nxt = vpat_pkg::ARB_LOAD;
                else if (!en_r)
                    state_nxt = vpat_pkg::ARB_IDLE;
                else if (!valid_r[cur_slot])
                begin
                    // Skipped slot spends only the step to the next phase
                    phase_nxt = next_phase(phase_r);
                    cnt_nxt   = '0;
                end
                else
                begin
                    gport_nxt = cur_slot;
                    gval_nxt  = 1'b1;
                    if (cnt_r + 8'h01 >= period_r)
                    begin
                        cnt_nxt   = '0;
                        phase_nxt = next_phase(phase_r);
                    end
                    else
                        cnt_nxt = cnt_r + 8'h01;
                end
            end
            vpat_pkg::ARB_LOAD:
            begin
                // Copy done in one cycle; walk restarts at phase 0
                active_nxt = shadow_r;
                phase_nxt  = vpat_pkg::PHASE_ZERO;
                cnt_nxt    = '0;
                state_nxt  = en_r ? vpat_pkg::ARB_RUN : vpat_pkg::ARB_IDLE;
            end
            default:
                state_nxt = vpat_pkg::ARB_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            state_r  <= vpat_pkg::ARB_IDLE;
            phase_r  <= vpat_pkg::PHASE_ZERO;
            cnt_r    <= '0;
            active_r <= {vpat_pkg::RST_TBL2, vpat_pkg::RST_TBL1, vpat_pkg::RST_TBL0};
            gport_r  <= '0;
            gval_r   <= 1'b0;
        end
        else
        begin
            state_r  <= state_nxt;
            phase_r  <= phase_nxt;
            cnt_r    <= cnt_nxt;
            active_r <= active_nxt;
            gport_r  <= gport_nxt;
            gval_r   <= gval_nxt;
        end
    end

    assign rdata_out                = rdata_r;
    assign grant_port_out           = gport_r;
    assign grant_valid_out          = gval_r;
    assign phase_out                = phase_r;
    assign table_coherence_flag_out = coh_r;

endmodule : vpat_arb_table

// [src/vpat_pkg.sv]
// Constants and types for the VC0 port arbitration table
package vpat_pkg;

    localparam int unsigned ADDR_W     = 12;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned SLOT_W     = 4;
    localparam int unsigned PHASES     = 24;
    localparam int unsigned PHASE_W    = 5;
    localparam int unsigned PORTS      = 16;
    localparam int unsigned PERIOD_W   = 8;

    typedef logic [ADDR_W-1:0]  vpat_addr_t;
    typedef logic [DATA_W-1:0]  vpat_word_t;
    typedef logic [SLOT_W-1:0]  vpat_slot_t;
    typedef logic [PHASE_W-1:0] vpat_phase_t;

    // Register byte addresses
    localparam vpat_addr_t OFF_TBL0   = 12'h230;
    localparam vpat_addr_t OFF_TBL1   = 12'h234;
    localparam vpat_addr_t OFF_TBL2   = 12'h238;
    localparam vpat_addr_t OFF_CTRL   = 12'h300;
    localparam vpat_addr_t OFF_STAT   = 12'h304;
    localparam vpat_addr_t OFF_VALID  = 12'h308;
    localparam vpat_addr_t OFF_PERIOD = 12'h30C;

    // Reset values
    localparam vpat_word_t RST_TBL0   = 32'h3322_1100;
    localparam vpat_word_t RST_TBL1   = 32'h7766_5544;
    localparam vpat_word_t RST_TBL2   = 32'hBBAA_9988;
    localparam logic [PORTS-1:0]    RST_VALID  = 16'hFFFF;
    localparam logic [PERIOD_W-1:0] RST_PERIOD = 8'h01;
    localparam vpat_word_t RD_ZERO    = 32'h0000_0000;

    // Control / status bit positions
    localparam int unsigned CTRL_LOAD_BIT = 0;
    localparam int unsigned CTRL_EN_BIT   = 1;
    localparam int unsigned STAT_COH_BIT  = 0;
    localparam int unsigned STAT_LOAD_BIT = 1;
    localparam int unsigned STAT_PH_LSB   = 8;

    localparam vpat_phase_t PHASE_LAST = 5'h17;
    localparam vpat_phase_t PHASE_ZERO = 5'h00;

    typedef enum logic [1:0]
    {
        ARB_IDLE = 2'b00,
        ARB_RUN  = 2'b01,
        ARB_LOAD = 2'b11
    } vpat_state_e;

    typedef struct packed
    {
        logic       wr;
        logic       rd;
        vpat_addr_t addr;
        vpat_word_t wdata;
    } vpat_req_s;

endpackage : vpat_pkg

// [test/vpat_arb_table_asserts.sv]
// Assertions on the ports of the VC0 port arbitration table
`timescale 1ns/1ps

module vpat_arb_table_asserts
(
    // Clock and reset
    input wire logic        mclk_in,
    input wire logic        rst_in,
    // Register port
    input wire logic [11:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [31:0] rdata_out,
    // Arbitration result
    input wire logic [3:0]  grant_port_out,
    input wire logic        grant_valid_out,
    input wire logic [4:0]  phase_out,
    input wire logic        table_coherence_flag_out
);

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    wire tbl_wr  = wr_in && addr_in inside {vpat_pkg::OFF_TBL0, vpat_pkg::OFF_TBL1,
                                            vpat_pkg::OFF_TBL2};
    wire load_wr = wr_in && (addr_in == vpat_pkg::OFF_CTRL) && wdata_in[0];
    wire mapped  = addr_in inside {vpat_pkg::OFF_TBL0, vpat_pkg::OFF_TBL1, vpat_pkg::OFF_TBL2,
                                   vpat_pkg::OFF_CTRL, vpat_pkg::OFF_STAT, vpat_pkg::OFF_VALID,
                                   vpat_pkg::OFF_PERIOD};

    ////////////////////////////////////////////////////////////////////////////////
    a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0000_0000)
        else $error("read data not zero outside read answer");
    a_unmapped_zero: assert property (rd_in && !mapped |=> rdata_out == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_coh_sets: assert property (tbl_wr |=> table_coherence_flag_out)
        else $error("coherence flag not set by table write");
    a_coh_clears: assert property ($fell(table_coherence_flag_out) |-> $past(load_wr, 2))
        else $error("coherence flag cleared without load");
    a_rst_quiet: assert property ($past(rst_in) |-> !table_coherence_flag_out
                                  && phase_out == 5'h00 && !grant_valid_out)
        else $error("outputs not quiet after reset");
    a_phase_range: assert property (phase_out <= vpat_pkg::PHASE_LAST)
        else $error("phase beyond last slot");
    a_phase_step: assert property ($changed(phase_out) |->
                                   phase_out == $past(phase_out) + 5'h01 || phase_out == 5'h00)
        else $error("phase did not step upward or wrap");
    a_load_restart: assert property (load_wr && wdata_in[1] |-> ##2 phase_out == 5'h00)
        else $error("load did not restart at phase zero");
    a_port_holds: assert property (!grant_valid_out |-> $stable(grant_port_out))
        else $error("granted port changed without a grant");

    c_grant: cover property (grant_valid_out ##1 !grant_valid_out);
    c_wrap: cover property (phase_out == vpat_pkg::PHASE_LAST ##1 phase_out == 5'h00);
    c_coh: cover property ($fell(table_coherence_flag_out));

endmodule : vpat_arb_table_asserts

bind vpat_arb_table vpat_arb_table_asserts i_chk (.mclk_in(mclk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .grant_port_out(grant_port_out),
    .grant_valid_out(grant_valid_out), .phase_out(phase_out),
    .table_coherence_flag_out(table_coherence_flag_out));

// [test/vpat_arb_table_bench.sv]
// Register and grant sequence tests for the VC0 port arbitration table
`timescale 1ns/1ps

module vpat_arb_table_bench;

    logic        mclk_in  = 1'b0;
    logic        rst_in   = 1'b1;
    logic [11:0] addr_in  = 12'h000;
    logic [31:0] wdata_in = 32'h0000_0000;
    logic        wr_in    = 1'b0;
    logic        rd_in    = 1'b0;
    logic [31:0] rdata_out;
    logic [3:0]  grant_port_out;
    logic        grant_valid_out;
    logic [4:0]  phase_out;
    logic        table_coherence_flag_out;
    int          failures    = 0;
    int          comparisons = 0;
    int          n;
    logic [3:0]  exp_q[$];
    logic [31:0] tbl[3] = '{32'h7654_3210, 32'hFEDC_BA98, 32'h0123_4567};

    vpat_arb_table i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .grant_port_out(grant_port_out), .grant_valid_out(grant_valid_out),
        .phase_out(phase_out), .table_coherence_flag_out(table_coherence_flag_out));

    initial forever #25 mclk_in = ~mclk_in;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge mclk_in);
        wr_in    <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge mclk_in);
        rd_in   <= 1'b0;
        #1;
        check($sformatf("rdata %h", a), exp, rdata_out);
    endtask : rd

    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (6000) @(posedge mclk_in);
        failures++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        #1;
        check("coherence", 32'h0, {31'h0, table_coherence_flag_out});
        rd(12'h230, 32'h3322_1100);
        rd(12'h234, 32'h7766_5544);
        rd(12'h238, 32'hBBAA_9988);
        wr(12'h23C, 32'h1234_5678);
        rd(12'h23C, 32'h0000_0000);
        $display("test reset_values done");

        wr(12'h230, tbl[0]);
        check("coherence", 32'h1, {31'h0, table_coherence_flag_out});
        wr(12'h234, tbl[1]);
        wr(12'h238, tbl[2]);
        for (int k = 0; k < 3; k++)
            rd(12'h230 + 12'(4 * k), tbl[k]);
        $display("test table_readback done");

        // Port 5 masked off, so its two phases must be skipped
        wr(vpat_pkg::OFF_VALID, 32'h0000_FFDF);
        for (int p = 0; p < 48; p++)
            if (tbl[(p % 24) / 8][4 * (p % 8) +: 4] != 4'h5)
                exp_q.push_back(tbl[(p % 24) / 8][4 * (p % 8) +: 4]);
        wr(vpat_pkg::OFF_CTRL, 32'h0000_0003);
        n = 0;
        for (int c = 0; c < 200 && n < 40; c++)
        begin
            @(posedge mclk_in);
            #1;
            if (grant_valid_out === 1'b1)
            begin
                check("grant_port", {28'h0, exp_q[n]}, {28'h0, grant_port_out});
                n++;
            end
        end
        check("grant_count", 32'h28, 32'(n));
        check("coherence", 32'h0, {31'h0, table_coherence_flag_out});
        $display("test grant_walk done");

        // Disable drops the walker back to idle at phase zero
        wr(vpat_pkg::OFF_CTRL, 32'h0000_0000);
        rd(vpat_pkg::OFF_CTRL, 32'h0000_0000);
        rd(vpat_pkg::OFF_STAT, 32'h0000_0000);
        check("grant_valid", 32'h0, {31'h0, grant_valid_out});
        $display("test disable done");

        // Table write in the cycle the load completes keeps the flag set
        wr(vpat_pkg::OFF_PERIOD, 32'h0000_0002);
        rd(vpat_pkg::OFF_PERIOD, 32'h0000_0002);
        @(posedge mclk_in);
        addr_in  <= vpat_pkg::OFF_CTRL;
        wdata_in <= 32'h0000_0003;
        wr_in    <= 1'b1;
        @(posedge mclk_in);
        addr_in  <= vpat_pkg::OFF_TBL0;
        wdata_in <= tbl[0];
        @(posedge mclk_in);
        wr_in    <= 1'b0;
        #1;
        check("coherence", 32'h1, {31'h0, table_coherence_flag_out});
        n = 0;
        for (int c = 0; c < 200 && n < 40; c++)
        begin
            @(posedge mclk_in);
            #1;
            if (grant_valid_out === 1'b1)
            begin
                check("grant_p2", {28'h0, exp_q[n / 2]}, {28'h0, grant_port_out});
                n++;
            end
        end
        check("grant_count_p2", 32'h28, 32'(n));
        $display("test period_two done");

        @(posedge mclk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        rd(12'h230, 32'h3322_1100);
        rd(12'h238, 32'hBBAA_9988);
        $display("test second_reset done");
        tally_and_finish();
    end

endmodule : vpat_arb_table_bench
